// ==== logic/ofd_pkg.sv ====
package ofd_pkg;

	// Prefix bytes that resize one instruction.
	localparam logic [7:0] OFD_OPSIZE_PREFIX = 8'h66;
	localparam logic [7:0] OFD_ADDRSIZE_PREFIX = 8'h67;

	// Field positions inside the addressing byte, the index byte and the opcode.
	localparam int OFD_MOD_MSB = 7;
	localparam int OFD_MOD_LSB = 6;
	localparam int OFD_MID_MSB = 5;
	localparam int OFD_MID_LSB = 3;
	localparam int OFD_LOW_MSB = 2;
	localparam int OFD_LOW_LSB = 0;
	localparam int OFD_SEG2_MSB = 4;
	localparam int OFD_SEG2_LSB = 3;

	// Mode field values and the unit scale value.
	localparam logic [1:0] OFD_MOD_NODISP = 2'h0;
	localparam logic [1:0] OFD_MOD_DISP_SHORT = 2'h1;
	localparam logic [1:0] OFD_MOD_DISP_FULL = 2'h2;
	localparam logic [1:0] OFD_MOD_REGISTER = 2'h3;
	localparam logic [1:0] OFD_SCALE_ONE = 2'h0;

	// Special low-field, base and index codes.
	localparam logic [2:0] OFD_RM_SIB = 3'h4;
	localparam logic [2:0] OFD_RM_FRAME = 3'h5;
	localparam logic [2:0] OFD_RM16_FRAME = 3'h6;
	localparam logic [2:0] OFD_INDEX_NONE = 3'h4;

	// General register numbers used by the 16-bit address forms; SP marks the stack base in the index byte form.
	localparam logic [2:0] OFD_GPR_BX = 3'h3;
	localparam logic [2:0] OFD_GPR_SP = 3'h4;
	localparam logic [2:0] OFD_GPR_FRAME_BASE_REGISTER = 3'h5;
	localparam logic [2:0] OFD_GPR_SI = 3'h6;
	localparam logic [2:0] OFD_GPR_DI = 3'h7;

	typedef enum logic [1:0] {OFD_SRC_OPCODE = 2'h0, OFD_SRC_MID = 2'h1, OFD_SRC_LOW = 2'h2} ofd_reg_src_t;
	typedef enum logic [1:0] {OFD_SEGF_NONE = 2'h0, OFD_SEGF_TWO_BIT = 2'h1, OFD_SEGF_THREE_BIT = 2'h2} ofd_seg_form_t;
	typedef enum logic [2:0] {
		OFD_SEG_EXTRA_SEGMENT = 3'h0,
		OFD_SEG_CODE_SEGMENT = 3'h1,
		OFD_SEG_STACK_SEGMENT = 3'h2,
		OFD_SEG_DATA_SEGMENT = 3'h3,
		OFD_SEG_FOURTH_DATA_SEGMENT = 3'h4,
		OFD_SEG_FIFTH_DATA_SEGMENT = 3'h5
	} ofd_seg_t;
	typedef enum logic [1:0] {OFD_SZ_BYTE_LOW = 2'h0, OFD_SZ_BYTE_HIGH = 2'h1, OFD_SZ_WORD = 2'h2,
		OFD_SZ_DWORD = 2'h3} ofd_opsz_t;
	typedef enum logic [1:0] {OFD_DISP_NONE = 2'h0, OFD_DISP_SHORT = 2'h1, OFD_DISP_WORD = 2'h2,
		OFD_DISP_LONG = 2'h3} ofd_disp_t;

	typedef struct packed {
		ofd_opsz_t size;
		logic [2:0] idx;
	} ofd_gpr_t;

	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
		logic [7:0] modrm;
		logic [7:0] sib;
		ofd_reg_src_t reg_src;
		logic mid_is_reg;
		logic has_modrm;
		logic has_w;
		logic w;
		ofd_seg_form_t seg_form;
	} ofd_req_t;

	typedef struct packed {
		logic valid;
		logic is_reg;
		ofd_gpr_t rm_reg;
		logic addr16;
		logic sib_needed;
		logic base_valid;
		logic [2:0] base;
		logic index_valid;
		logic [2:0] index;
		logic [1:0] scale;
		ofd_disp_t disp;
		ofd_seg_t seg;
		logic undefined;
	} ofd_ea_t;

	typedef struct packed {
		logic valid;
		ofd_gpr_t gpr;
		logic opext_valid;
		logic [2:0] opext;
		logic seg_valid;
		ofd_seg_t seg_sel;
		logic seg_bad;
		ofd_ea_t ea;
	} ofd_rsp_t;

	typedef struct packed {
		logic opsize_pend;
		logic addrsize_pend;
		ofd_rsp_t rsp;
	} ofd_state_t;

endpackage

// ==== logic/ofd_operand_field_decoder.sv ====
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Register selector comes from opcode bits, addressing byte middle, or addressing byte low field.
// [RULE_02] Without width bit, code n picks register n, 32-bit, or 16-bit with size prefix.
// [RULE_03] Width bit 0 picks low or second bytes of registers 0-3; 1 picks full size.
// [RULE_04] Two-bit segment code maps to extra, code, stack, data segments.
// [RULE_05] Three-bit segment code adds fourth and fifth data segments; 110 and 111 unusable.
// [RULE_06] Addressing mode comes from the addressing byte unless the instruction implies it.
// [RULE_07] In 32-bit addressing, low field 100 with mode 00/01/10 means index byte follows.
// [RULE_08] With index byte, address form comes from mode, scale, index and base fields.
// [RULE_09] Addressing byte middle bits are an opcode extension or a register selector.
// [RULE_10] Addressing byte uses 16-bit components in 16-bit addressing, 32-bit components otherwise.
// [RULE_11] Mode 00 picks data segment at register n; 101 is bare long displacement.
// [RULE_12] Modes 01/10 add short/long displacement; low field 101 uses frame base, stack segment.
// [RULE_13] Mode 11 is a register operand, byte or full size by width bit.
// [RULE_14] Prefix 66H makes full-size operands 16 bits for the next instruction only.
// [RULE_15] Prefix 67H switches the next instruction's address calculation to 16 bits.
// [RULE_16] Width bit 0 selects a byte operand, 1 a full-size operand.
module ofd_operand_field_decoder (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic pfx_valid_i,
	input wire logic [7:0] pfx_byte_i,
	input wire ofd_pkg::ofd_req_t req_i,
	output ofd_pkg::ofd_rsp_t rsp_o
);
	import ofd_pkg::*;

	ofd_state_t st_q;
	ofd_state_t st_d;

	// Maps a three-bit register code onto a register number and an operand size.
	function automatic ofd_gpr_t decode_gpr(input logic [2:0] code, input logic has_w, input logic w,
		input logic opsz16);
		ofd_gpr_t g;
		if (has_w && !w) begin
			// Codes with the top bit set reach the second byte of registers 0 to 3.
			g.size = code[2] ? OFD_SZ_BYTE_HIGH : OFD_SZ_BYTE_LOW; // [RULE_03] [RULE_16]
			g.idx = {1'b0, code[1:0]}; // [RULE_03]
		end else begin
			g.size = opsz16 ? OFD_SZ_WORD : OFD_SZ_DWORD; // [RULE_02] [RULE_14]
			g.idx = code; // [RULE_02]
		end
		return g;
	endfunction

	// Builds the 16-bit address form from mode and low field.
	function automatic ofd_ea_t decode_ea16(input logic [1:0] md, input logic [2:0] rm);
		ofd_ea_t e;
		e = '0;
		e.addr16 = 1'b1;
		e.base_valid = 1'b1;
		e.seg = OFD_SEG_DATA_SEGMENT;
		case (rm)
			3'h0: begin
				e.base = OFD_GPR_BX;
				e.index_valid = 1'b1;
				e.index = OFD_GPR_SI;
			end
			3'h1: begin
				e.base = OFD_GPR_BX;
				e.index_valid = 1'b1;
				e.index = OFD_GPR_DI;
			end
			3'h2: begin
				e.base = OFD_GPR_FRAME_BASE_REGISTER;
				e.index_valid = 1'b1;
				e.index = OFD_GPR_SI;
				e.seg = OFD_SEG_STACK_SEGMENT;
			end
			3'h3: begin
				e.base = OFD_GPR_FRAME_BASE_REGISTER;
				e.index_valid = 1'b1;
				e.index = OFD_GPR_DI;
				e.seg = OFD_SEG_STACK_SEGMENT;
			end
			3'h4: begin
				e.base = OFD_GPR_SI;
			end
			3'h5: begin
				e.base = OFD_GPR_DI;
			end
			3'h6: begin
				e.base = OFD_GPR_FRAME_BASE_REGISTER;
				e.seg = OFD_SEG_STACK_SEGMENT;
			end
			default: begin
				e.base = OFD_GPR_BX;
			end
		endcase
		// Mode 00 with the frame code is a bare word displacement, so the frame base drops out.
		case (md)
			OFD_MOD_DISP_SHORT: e.disp = OFD_DISP_SHORT;
			OFD_MOD_DISP_FULL: e.disp = OFD_DISP_WORD;
			default: begin
				if (rm == OFD_RM16_FRAME) begin
					e.disp = OFD_DISP_WORD;
					e.base_valid = 1'b0;
					e.base = '0;
					e.seg = OFD_SEG_DATA_SEGMENT;
				end else begin
					e.disp = OFD_DISP_NONE;
				end
			end
		endcase
		return e;
	endfunction

	// Builds the 32-bit address form, with or without the index byte.
	function automatic ofd_ea_t decode_ea32(input logic [1:0] md, input logic [2:0] rm, input logic [7:0] sib);
		ofd_ea_t e;
		logic [2:0] base;
		e = '0;
		base = rm;
		e.base_valid = 1'b1;
		e.seg = OFD_SEG_DATA_SEGMENT;
		if (rm == OFD_RM_SIB) begin
			e.sib_needed = 1'b1; // [RULE_07]
			base = sib[OFD_LOW_MSB:OFD_LOW_LSB]; // [RULE_08]
			e.scale = sib[OFD_MOD_MSB:OFD_MOD_LSB]; // [RULE_08]
			e.index = sib[OFD_MID_MSB:OFD_MID_LSB]; // [RULE_08]
			e.index_valid = (e.index != OFD_INDEX_NONE); // [RULE_08]
			// A missing index with a non-unit scale leaves the address undefined.
			e.undefined = !e.index_valid && (e.scale != OFD_SCALE_ONE); // [RULE_08]
			if (base == OFD_GPR_SP) begin
				e.seg = OFD_SEG_STACK_SEGMENT; // [RULE_08]
			end
		end
		e.base = base;
		case (md)
			OFD_MOD_DISP_SHORT: e.disp = OFD_DISP_SHORT; // [RULE_12]
			OFD_MOD_DISP_FULL: e.disp = OFD_DISP_LONG; // [RULE_12]
			default: e.disp = OFD_DISP_NONE; // [RULE_11]
		endcase
		if (base == OFD_RM_FRAME) begin
			if (md == OFD_MOD_NODISP) begin
				// Mode 00 with code 101 carries no base, only a long displacement.
				e.base_valid = 1'b0; // [RULE_11] [RULE_08]
				e.base = '0;
				e.disp = OFD_DISP_LONG; // [RULE_11]
			end else begin
				e.seg = OFD_SEG_STACK_SEGMENT; // [RULE_12]
			end
		end
		return e;
	endfunction

	// Next-state logic: prefix capture, field routing and address decoding.
	always_comb begin
		logic opsz16;
		logic adsz16;
		logic [1:0] md;
		logic [2:0] mid;
		logic [2:0] low;
		logic [2:0] code;
		logic [2:0] seg3;
		opsz16 = 1'b0;
		adsz16 = 1'b0;
		md = '0;
		mid = '0;
		low = '0;
		code = '0;
		seg3 = '0;
		st_d = st_q;
		st_d.rsp.valid = 1'b0;
		// A prefix in the same cycle as the instruction still belongs to it.
		opsz16 = st_q.opsize_pend || (pfx_valid_i && pfx_byte_i == OFD_OPSIZE_PREFIX); // [RULE_14]
		adsz16 = st_q.addrsize_pend || (pfx_valid_i && pfx_byte_i == OFD_ADDRSIZE_PREFIX); // [RULE_15]
		md = req_i.modrm[OFD_MOD_MSB:OFD_MOD_LSB];
		mid = req_i.modrm[OFD_MID_MSB:OFD_MID_LSB];
		low = req_i.modrm[OFD_LOW_MSB:OFD_LOW_LSB];
		if (req_i.valid) begin
			// Prefixes are consumed by this instruction and never carried to the next.
			st_d.opsize_pend = 1'b0; // [RULE_14]
			st_d.addrsize_pend = 1'b0; // [RULE_15]
			st_d.rsp = '0;
			st_d.rsp.valid = 1'b1;
			// General register selector source.
			case (req_i.reg_src)
				OFD_SRC_MID: code = mid; // [RULE_01]
				OFD_SRC_LOW: code = low; // [RULE_01]
				default: code = req_i.opcode[OFD_LOW_MSB:OFD_LOW_LSB]; // [RULE_01]
			endcase
			st_d.rsp.gpr = decode_gpr(code, req_i.has_w, req_i.w, opsz16);
			// Middle bits go out as an extension when the opcode does not use them as a register.
			st_d.rsp.opext_valid = req_i.has_modrm && !req_i.mid_is_reg; // [RULE_09]
			st_d.rsp.opext = st_d.rsp.opext_valid ? mid : 3'h0; // [RULE_09]
			// Segment register field, two-bit form in the opcode, three-bit form in the middle bits.
			case (req_i.seg_form)
				OFD_SEGF_TWO_BIT: begin
					st_d.rsp.seg_valid = 1'b1;
					st_d.rsp.seg_sel = ofd_seg_t'({1'b0, req_i.opcode[OFD_SEG2_MSB:OFD_SEG2_LSB]}); // [RULE_04]
				end
				OFD_SEGF_THREE_BIT: begin
					seg3 = mid;
					if (seg3 > OFD_SEG_FIFTH_DATA_SEGMENT) begin
						// Unusable code: flagged, and the selection is parked on the data segment.
						st_d.rsp.seg_bad = 1'b1; // [RULE_05]
						st_d.rsp.seg_sel = OFD_SEG_DATA_SEGMENT;
					end else begin
						st_d.rsp.seg_valid = 1'b1;
						st_d.rsp.seg_sel = ofd_seg_t'(seg3); // [RULE_05]
					end
				end
				default: begin
					st_d.rsp.seg_sel = OFD_SEG_DATA_SEGMENT;
				end
			endcase
			// Implied addressing leaves the address form empty.
			if (req_i.has_modrm) begin // [RULE_06]
				if (md == OFD_MOD_REGISTER) begin
					st_d.rsp.ea.is_reg = 1'b1; // [RULE_13]
					st_d.rsp.ea.rm_reg = decode_gpr(low, req_i.has_w, req_i.w, opsz16); // [RULE_13]
					st_d.rsp.ea.seg = OFD_SEG_DATA_SEGMENT;
				end else if (adsz16) begin
					st_d.rsp.ea = decode_ea16(md, low); // [RULE_10]
				end else begin
					st_d.rsp.ea = decode_ea32(md, low, req_i.sib); // [RULE_10]
				end
				st_d.rsp.ea.valid = 1'b1; // [RULE_06]
				st_d.rsp.ea.addr16 = adsz16; // [RULE_15]
			end
		end else if (pfx_valid_i) begin
			// Other prefix bytes pass by without effect here.
			if (pfx_byte_i == OFD_OPSIZE_PREFIX) begin
				st_d.opsize_pend = 1'b1; // [RULE_14]
			end
			if (pfx_byte_i == OFD_ADDRSIZE_PREFIX) begin
				st_d.addrsize_pend = 1'b1; // [RULE_15]
			end
		end
	end

	// State register; the answer fields are held until the next instruction replaces them, but valid lasts one cycle.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp_o = st_q.rsp;

endmodule // ofd_operand_field_decoder

// ==== dv/ofd_checker.sv ====
`timescale 1ns/1ps
// Judges each answer against the fields taken one edge earlier.
module ofd_checker (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic pfx_valid_i,
	input wire logic [7:0] pfx_byte_i,
	input wire ofd_pkg::ofd_req_t req_i,
	input wire ofd_pkg::ofd_rsp_t rsp_o
);
	import ofd_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	logic ans;
	logic mem;
	// Memory answers only; register forms carry no displacement.
	assign ans = rsp_o.valid && rsp_o.ea.valid;
	assign mem = ans && !rsp_o.ea.is_reg;
	ofd_seg_t seg2_ref;
	// Two-bit segment codes written out one by one, so the check does not lean on the enum order.
	always_comb begin
		case (req_i.opcode[4:3])
			2'h0: seg2_ref = OFD_SEG_EXTRA_SEGMENT;
			2'h1: seg2_ref = OFD_SEG_CODE_SEGMENT;
			2'h2: seg2_ref = OFD_SEG_STACK_SEGMENT;
			default: seg2_ref = OFD_SEG_DATA_SEGMENT;
		endcase
	end
	// A request and its answer on the next edge.
	sequence s_take;
		req_i.valid ##1 rsp_o.valid;
	endsequence
	chk_ea_valid: assert property (s_take |-> rsp_o.ea.valid == $past(req_i.has_modrm))
		else $error("addressing flag wrong");
	chk_mode_reg: assert property (ans |->
		rsp_o.ea.is_reg == ($past(req_i.modrm[7:6]) == OFD_MOD_REGISTER))
		else $error("register mode wrong");
	chk_sib_flag: assert property (mem && !rsp_o.ea.addr16 |->
		rsp_o.ea.sib_needed == ($past(req_i.modrm[2:0]) == 3'h4))
		else $error("index byte flag wrong");
	chk_short_disp: assert property (mem && $past(req_i.modrm[7:6]) == 2'h1 |->
		rsp_o.ea.disp == OFD_DISP_SHORT)
		else $error("short displacement wrong");
	chk_bare_disp: assert property (mem && !rsp_o.ea.addr16 && $past(req_i.modrm[7:6]) == 2'h0 &&
		$past(req_i.modrm[2:0]) == 3'h5 |->
		!rsp_o.ea.base_valid && rsp_o.ea.disp == OFD_DISP_LONG && rsp_o.ea.seg == OFD_SEG_DATA_SEGMENT)
		else $error("bare displacement wrong");
	chk_seg_two: assert property (rsp_o.valid && $past(req_i.seg_form) == OFD_SEGF_TWO_BIT |->
		rsp_o.seg_valid && rsp_o.seg_sel == $past(seg2_ref))
		else $error("two-bit segment wrong");
	chk_seg_bad: assert property (rsp_o.valid && $past(req_i.seg_form) == OFD_SEGF_THREE_BIT |->
		rsp_o.seg_bad == ($past(req_i.modrm[5:4]) == 2'h3))
		else $error("unusable segment wrong");
	chk_opext_route: assert property (ans |-> rsp_o.opext_valid != $past(req_i.mid_is_reg))
		else $error("extension routing wrong");
	chk_byte_width: assert property (rsp_o.valid && $past(req_i.has_w && !req_i.w) |->
		rsp_o.gpr.size inside {OFD_SZ_BYTE_LOW, OFD_SZ_BYTE_HIGH})
		else $error("byte width wrong");
endmodule // ofd_checker
bind ofd_operand_field_decoder ofd_checker ofd_checker_i (.mclk_i(mclk_i), .srst_i(srst_i),
	.pfx_valid_i(pfx_valid_i), .pfx_byte_i(pfx_byte_i), .req_i(req_i), .rsp_o(rsp_o));

// ==== dv/ofd_fetch_model.sv ====
`timescale 1ns/1ps
// Prefetch side: prefix bytes one per cycle, then the instruction fields.
module ofd_fetch_model (
	input wire logic mclk_i,
	output logic pfx_valid_o,
	output logic [7:0] pfx_byte_o,
	output ofd_pkg::ofd_req_t req_o
);
	import ofd_pkg::*;
	initial begin
		pfx_valid_o = 1'b0;
		pfx_byte_o = 8'h00;
		req_o = '0;
	end
	// One cycle; an idle prefix byte flips so it never repeats the byte of the cycle before.
	task automatic step(input logic pv, input logic [7:0] pb, input ofd_req_t r);
		pfx_valid_o <= pv;
		pfx_byte_o <= pv ? pb : ~pfx_byte_o;
		req_o <= r;
		@(posedge mclk_i);
	endtask
	task automatic issue(input logic p66, input logic p67, input ofd_req_t r);
		ofd_req_t idle;
		idle = r;
		idle.valid = 1'b0;
		if (p66) step(1'b1, OFD_OPSIZE_PREFIX, idle);
		if (p67) step(1'b1, OFD_ADDRSIZE_PREFIX, idle);
		r.valid = 1'b1;
		step(1'b0, 8'h00, r);
	endtask
endmodule // ofd_fetch_model

// ==== dv/ofd_operand_field_decoder_test.sv ====
`timescale 1ns/1ps
// Random instructions through the prefetch model, checked against a reference decode.
module ofd_operand_field_decoder_test;
	import ofd_pkg::*;
	typedef struct packed {logic p66; logic p67; ofd_req_t r;} ofd_job_t;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic pfx_valid_i;
	logic [7:0] pfx_byte_i;
	ofd_req_t req_i;
	ofd_rsp_t rsp_o;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h75a9;
	logic [7:0] corner [8] = '{8'hc1, 8'h44, 8'h05, 8'h45, 8'h85, 8'h04, 8'h06, 8'hf4};
	ofd_job_t jobs[$];
	always #12.5 mclk_i = ~mclk_i;
	ofd_fetch_model ofd_fetch_model_i (.mclk_i(mclk_i), .pfx_valid_o(pfx_valid_i), .pfx_byte_o(pfx_byte_i),
		.req_o(req_i));
	ofd_operand_field_decoder ofd_operand_field_decoder_i (.mclk_i(mclk_i), .srst_i(srst_i),
		.pfx_valid_i(pfx_valid_i), .pfx_byte_i(pfx_byte_i), .req_i(req_i), .rsp_o(rsp_o));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Byte codes 4 to 7 reach the second byte of registers 0 to 3.
	function automatic ofd_gpr_t gpr(input logic [2:0] c, input logic b, input logic p66);
		if (b) return '{c[2] ? OFD_SZ_BYTE_HIGH : OFD_SZ_BYTE_LOW, {1'b0, c[1:0]}};
		return '{p66 ? OFD_SZ_WORD : OFD_SZ_DWORD, c};
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input ofd_job_t j);
		ofd_req_t r;
		logic [2:0] c, m, s, b;
		logic [1:0] md;
		r = j.r;
		md = r.modrm[7:6];
		m = r.modrm[2:0];
		s = r.modrm[5:3];
		b = r.sib[2:0];
		c = r.reg_src == OFD_SRC_OPCODE ? r.opcode[2:0] : (r.reg_src == OFD_SRC_MID ? s : m);
		cmp(8'(rsp_o.gpr), 8'(gpr(c, r.has_w && !r.w, j.p66)));
		if (r.seg_form == OFD_SEGF_TWO_BIT) cmp(8'({rsp_o.seg_valid, rsp_o.seg_bad, rsp_o.seg_sel}),
			8'({3'h4, r.opcode[4:3]}));
		if (r.seg_form == OFD_SEGF_THREE_BIT) cmp(8'({rsp_o.seg_valid, rsp_o.seg_bad, rsp_o.seg_sel}),
			8'(s[2:1] == 2'h3 ? 5'h0b : {2'h2, s}));
		cmp(8'({rsp_o.ea.valid, rsp_o.opext_valid}), 8'({r.has_modrm, r.has_modrm && !r.mid_is_reg}));
		if (!r.has_modrm) return;
		cmp(8'(rsp_o.opext), 8'(r.mid_is_reg ? 3'h0 : s));
		cmp(8'({rsp_o.ea.is_reg, rsp_o.ea.addr16}), 8'({md == 2'h3, j.p67}));
		if (md == 2'h3) begin
			if (r.has_w) cmp(8'(rsp_o.ea.rm_reg), 8'(gpr(m, !r.w, j.p66)));
			return;
		end
		if (j.p67) begin
			cmp(8'({rsp_o.ea.sib_needed, rsp_o.ea.disp}), 8'(md == 2'h1 ? OFD_DISP_SHORT :
				(md == 2'h2 || m == OFD_RM16_FRAME ? OFD_DISP_WORD : OFD_DISP_NONE)));
			cmp(8'(rsp_o.ea.seg), 8'((m[2:1] == 2'h1 || (m == 3'h6 && md != 2'h0)) ?
				OFD_SEG_STACK_SEGMENT : OFD_SEG_DATA_SEGMENT));
			return;
		end
		if (m != OFD_RM_SIB) begin
			cmp(8'({rsp_o.ea.sib_needed, rsp_o.ea.disp, rsp_o.ea.seg}), 8'({1'b0, md == 2'h0 ?
				(m == 3'h5 ? OFD_DISP_LONG : OFD_DISP_NONE) : (md == 2'h1 ? OFD_DISP_SHORT : OFD_DISP_LONG),
				md != 2'h0 && m == 3'h5 ? OFD_SEG_STACK_SEGMENT : OFD_SEG_DATA_SEGMENT}));
			if (md != 2'h0 || m != 3'h5) cmp(8'({rsp_o.ea.base_valid, rsp_o.ea.base}), 8'({1'b1, m}));
			return;
		end
		cmp(8'({rsp_o.ea.sib_needed, rsp_o.ea.undefined, rsp_o.ea.scale, rsp_o.ea.index}),
			8'({1'b1, r.sib[5:3] == 3'h4 && r.sib[7:6] != 2'h0, r.sib[7:0] & 8'hf8} >> 3));
		cmp(8'(rsp_o.ea.seg), 8'(b == 3'h4 || (b == 3'h5 && md != 2'h0) ? OFD_SEG_STACK_SEGMENT
			: OFD_SEG_DATA_SEGMENT));
		cmp(8'({rsp_o.ea.base_valid, rsp_o.ea.base, rsp_o.ea.index_valid, rsp_o.ea.disp}),
			8'({md == 2'h0 && b == 3'h5 ? 4'h0 : {1'b1, b}, r.sib[5:3] != 3'h4,
			md == 2'h1 ? OFD_DISP_SHORT : (md == 2'h2 || b == 3'h5 ? OFD_DISP_LONG : OFD_DISP_NONE)}));
	endtask
	// Answers are read mid-cycle, after the registered outputs settle.
	always @(negedge mclk_i) begin
		if (rsp_o.valid === 1'b1) begin
			if (jobs.size() == 0) cmp(8'h01, 8'h00);
			else check(jobs.pop_front());
		end
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			conclude();
		end
	end
	// Mostly back-to-back requests, a few gaps, each prefix kind on about a quarter of them.
	initial begin
		ofd_job_t j;
		logic [31:0] v;
		repeat (16) @(posedge mclk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 400; i++) begin
			v = rnd();
			j.r = ofd_req_t'(33'({rnd(), rnd()}));
			j.r.reg_src = ofd_reg_src_t'(v[1:0] % 2'h3);
			j.r.seg_form = ofd_seg_form_t'(v[3:2] % 2'h3);
			j.p66 = v[4] & v[5];
			j.p67 = v[6] & v[7];
			if (i < 8) {j.r.modrm, j.r.has_modrm, j.p67} = {corner[i], 2'h2};
			if (i == 0) {j.p66, j.r.has_w, j.r.w} = 3'h7;
			jobs.push_back(j);
			ofd_fetch_model_i.issue(j.p66, j.p67, j.r);
			if (v[8] & v[9]) ofd_fetch_model_i.step(1'b0, 8'h00, '0);
		end
		ofd_fetch_model_i.step(1'b0, 8'h00, '0);
		repeat (3) @(posedge mclk_i);
		cmp(8'(jobs.size()), 8'h00);
		conclude();
	end
endmodule // ofd_operand_field_decoder_test
